// *** hw/fetch_bus_ctl.sv ***
// instruction sequencing and shared bus command logic
// ---------------------------------------------------------------
// Function
// - reset clears index store and flip-flops, drives bus to zero
// - after reset fetch starts at address zero with bank line zero
// - one-word instruction takes 8 clocks, two-word takes 16
// - word splits into upper operation code and lower modifier
// - second word gives middle and low address or high and low data
// - operation code fetched in first fetch subcycle, modifier second
// - pair mode: even register gets high nibble, odd gets low
// - four 12-bit address registers, counter bumps after last slice
// - call pushes counter, returns to call plus 2; return pops
// - three return levels; fourth call loses the oldest
// - select-target sends pair in X2 and X3, bank line at X2
// - bank designate copies accumulator code, effective next instr
// - I/O or RAM instruction raises bank line during M2
// - modifier bit 3 zero means write, one means read
// - input or output enable strobe moves a nibble at X2
// - input latch clear issued after each input instruction
// - cycle-start marker once every 8 clocks
// - address sent as three slices, then fetch and execute
// - one driver per data line at any time
// ---------------------------------------------------------------
`timescale 1ns/1ps
module fetch_bus_ctl
(
  input  wire logic                               ref_clk,
  input  wire logic                               reset_n,
  input  wire logic [fetch_ctl_pkg::NIB_W-1:0]    dataBusIn,
  output logic      [fetch_ctl_pkg::NIB_W-1:0]    dataBusOut,
  output logic      [fetch_ctl_pkg::NIB_W-1:0]    dataBusOe_n,
  input  wire logic [fetch_ctl_pkg::NIB_W-1:0]    accIn,
  input  wire logic                               condTrue,
  output logic                                    cycleStart,
  output logic      [fetch_ctl_pkg::BANK_LINES-1:0] ramBankCmd,
  output logic                                    progMemCmd,
  output logic                                    portAddrLoad,
  output logic                                    inputEnable,
  output logic                                    outputEnable,
  output logic                                    inputLatchClear,
  output logic      [fetch_ctl_pkg::NIB_W-1:0]    opcodeField,
  output logic      [fetch_ctl_pkg::NIB_W-1:0]    modifierField,
  output logic                                    secondWord
);
  import fetch_ctl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  subcycle_t         sub_reg;
  subcycle_t         sub_next;
  logic              second_reg;
  logic              second_next;
  logic [NIB_W-1:0]  opcode_reg;
  logic [NIB_W-1:0]  opcode_next;
  logic [NIB_W-1:0]  modifier_reg;
  logic [NIB_W-1:0]  modifier_next;
  logic [NIB_W-1:0]  word2Hi_reg;
  logic [NIB_W-1:0]  word2Hi_next;
  logic [NIB_W-1:0]  word2Lo_reg;
  logic [NIB_W-1:0]  word2Lo_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic [ADDR_W-1:0] stack_reg [STACK_LVLS];
  logic [ADDR_W-1:0] stack_next [STACK_LVLS];
  logic [BANK_W-1:0] bank_reg;
  logic [BANK_W-1:0] bank_next;

  logic [NIB_W-1:0]      busOut_reg;
  logic [NIB_W-1:0]      busOut_next;
  logic [NIB_W-1:0]      busOeN_reg;
  logic [NIB_W-1:0]      busOeN_next;
  logic                  start_reg;
  logic                  start_next;
  logic [BANK_LINES-1:0] ramCmd_reg;
  logic [BANK_LINES-1:0] ramCmd_next;
  logic                  progCmd_reg;
  logic                  progCmd_next;
  logic                  addrLoad_reg;
  logic                  addrLoad_next;
  logic                  inEn_reg;
  logic                  inEn_next;
  logic                  outEn_reg;
  logic                  outEn_next;
  logic                  latchClr_reg;
  logic                  latchClr_next;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic              resetLevel;
  logic              isDouble;
  logic              isSelect;
  logic              isIo;
  logic              isRead;
  logic              opNowIo;
  logic              idxWrite;
  logic [IDX_AW-1:0] idxWAddr;
  logic [IDX_AW-1:0] idxRAddr;
  logic [NIB_W-1:0]  idxRData;
  logic [BANK_LINES-1:0] bankLine;

  // stretched pin copy drives the sweep; core flops use the pin itself
  pin_sync3 u_reset_sync
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pinIn    (1'b1),
    .pinLevel (resetLevel)
  );

  index_reg_file u_index
  (
    .ref_clk    (ref_clk),
    .sweepClear (!resetLevel),
    .writeEn    (idxWrite),
    .writeAddr  (idxWAddr),
    .writeData  (dataBusIn),
    .readAddr   (idxRAddr),
    .readData   (idxRData)
  );

  always_comb
  begin
    isDouble = (opcode_reg == OP_COND_JUMP) ||
               (opcode_reg == OP_JUMP) ||
               (opcode_reg == OP_CALL) ||
               (opcode_reg == OP_SKIP_ZERO) ||
               ((opcode_reg == OP_PAIR_GROUP) &&
                !modifier_reg[PAIR_BIT]);
    isSelect = (opcode_reg == OP_PAIR_GROUP) &&
               modifier_reg[PAIR_BIT];
    isIo     = (opcode_reg == OP_IO_GROUP);
    isRead   = modifier_reg[DIR_BIT];
    opNowIo  = (dataBusIn == OP_IO_GROUP) && !second_reg;
    bankLine = '0;
    bankLine[bank_reg[1:0]] = 1'b1;
    // pair load from second word: even gets upper, odd gets lower
    idxWrite = second_reg &&
               (opcode_reg == OP_PAIR_GROUP) &&
               ((sub_reg == SUB_M1) || (sub_reg == SUB_M2));
    idxWAddr = {modifier_reg[3:1], (sub_reg == SUB_M2)};
    idxRAddr = {modifier_reg[3:1], (sub_next == SUB_X3)};
  end

  // ---------------------------------------------------------------
  // sequencing, fetch and address store
  // ---------------------------------------------------------------
  always_comb
  begin
    sub_next      = (sub_reg == SUB_X3) ? SUB_A1
                                        : subcycle_t'(sub_reg + 3'h1);
    second_next   = second_reg;
    opcode_next   = opcode_reg;
    modifier_next = modifier_reg;
    word2Hi_next  = word2Hi_reg;
    pc_next       = pc_reg;
    stack_next    = stack_reg;
    bank_next     = bank_reg;
    unique case (sub_reg)
      SUB_A3:
        pc_next = pc_reg + 12'h001;
      SUB_M1:
        if (second_reg)
          word2Hi_next = dataBusIn;
        else
          opcode_next = dataBusIn;
      SUB_M2:
        if (!second_reg)
          modifier_next = dataBusIn;
      SUB_X3:
      begin
        if (!second_reg)
        begin
          second_next = isDouble;
          if (opcode_reg == OP_RETURN)
          begin
            pc_next = stack_reg[0];
            stack_next[0] = stack_reg[1];
            stack_next[1] = stack_reg[2];
          end
          if ((opcode_reg == OP_ACC_GROUP) &&
              (modifier_reg == MOD_BANK_DESIGNATE))
            bank_next = accIn[BANK_W-1:0];
        end
        else
        begin
          second_next = 1'b0;
          // pc already moved twice past the call word
          if (opcode_reg == OP_CALL)
          begin
            stack_next[0] = pc_reg;
            stack_next[1] = stack_reg[0];
            stack_next[2] = stack_reg[1];
          end
          if ((opcode_reg == OP_JUMP) || (opcode_reg == OP_CALL) ||
              (((opcode_reg == OP_COND_JUMP) ||
                (opcode_reg == OP_SKIP_ZERO)) && condTrue))
          begin
            if ((opcode_reg == OP_JUMP) || (opcode_reg == OP_CALL))
              pc_next = {modifier_reg, word2Hi_reg,
                         word2Lo_reg};
            else
              pc_next = {pc_reg[11:8], word2Hi_reg, word2Lo_reg};
          end
        end
      end
      default:
      begin
      end
    endcase
  end

  // low nibble of the second word is only held on the bus in M2

  always_comb
  begin
    word2Lo_next = word2Lo_reg;
    if (second_reg && (sub_reg == SUB_M2))
      word2Lo_next = dataBusIn;
  end

  // ---------------------------------------------------------------
  // bus and command outputs, computed for the coming subcycle
  // ---------------------------------------------------------------
  always_comb
  begin
    busOut_next   = NIB_ZERO;
    busOeN_next   = '1;
    start_next    = (sub_next == SUB_A1);
    ramCmd_next   = '0;
    progCmd_next  = 1'b0;
    addrLoad_next = 1'b0;
    inEn_next     = 1'b0;
    outEn_next    = 1'b0;
    latchClr_next = 1'b0;
    unique case (sub_next)
      SUB_A1:
      begin
        busOut_next = pc_next[3:0];
        busOeN_next = '0;
      end
      SUB_A2:
      begin
        busOut_next = pc_reg[7:4];
        busOeN_next = '0;
      end
      SUB_A3:
      begin
        busOut_next  = pc_reg[11:8];
        busOeN_next  = '0;
        progCmd_next = 1'b1;
      end
      SUB_M2:
        if (opNowIo)
          ramCmd_next = bankLine;
      SUB_X2:
        if (!second_reg && isSelect)
        begin
          busOut_next   = idxRData;
          busOeN_next   = '0;
          ramCmd_next   = bankLine;
          progCmd_next  = 1'b1;
          addrLoad_next = 1'b1;
        end
        else if (!second_reg && isIo)
        begin
          if (isRead)
            inEn_next = 1'b1;
          else
          begin
            outEn_next  = 1'b1;
            busOut_next = accIn;
            busOeN_next = '0;
          end
        end
      SUB_X3:
        if (!second_reg && isSelect)
        begin
          busOut_next = idxRData;
          busOeN_next = '0;
        end
        else if (!second_reg && isIo && isRead)
          latchClr_next = 1'b1;
      default:
      begin
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // bus held at driven zero while in reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sub_reg      <= SUB_X3;
      second_reg   <= 1'b0;
      opcode_reg   <= NIB_ZERO;
      modifier_reg <= NIB_ZERO;
      word2Hi_reg  <= NIB_ZERO;
      word2Lo_reg  <= NIB_ZERO;
      pc_reg       <= PC_RESET;
      stack_reg    <= '{default: PC_RESET};
      bank_reg     <= BANK_RESET;
      busOut_reg   <= NIB_ZERO;
      busOeN_reg   <= '0;
      start_reg    <= 1'b0;
      ramCmd_reg   <= '0;
      progCmd_reg  <= 1'b0;
      addrLoad_reg <= 1'b0;
      inEn_reg     <= 1'b0;
      outEn_reg    <= 1'b0;
      latchClr_reg <= 1'b0;
    end
    else
    begin
      sub_reg      <= sub_next;
      second_reg   <= second_next;
      opcode_reg   <= opcode_next;
      modifier_reg <= modifier_next;
      word2Hi_reg  <= word2Hi_next;
      word2Lo_reg  <= word2Lo_next;
      pc_reg       <= pc_next;
      stack_reg    <= stack_next;
      bank_reg     <= bank_next;
      busOut_reg   <= busOut_next;
      busOeN_reg   <= busOeN_next;
      start_reg    <= start_next;
      ramCmd_reg   <= ramCmd_next;
      progCmd_reg  <= progCmd_next;
      addrLoad_reg <= addrLoad_next;
      inEn_reg     <= inEn_next;
      outEn_reg    <= outEn_next;
      latchClr_reg <= latchClr_next;
    end
  end

  assign dataBusOut      = busOut_reg;
  assign dataBusOe_n     = busOeN_reg;
  assign cycleStart      = start_reg;
  assign ramBankCmd      = ramCmd_reg;
  assign progMemCmd      = progCmd_reg;
  assign portAddrLoad    = addrLoad_reg;
  assign inputEnable     = inEn_reg;
  assign outputEnable    = outEn_reg;
  assign inputLatchClear = latchClr_reg;
  assign opcodeField     = opcode_reg;
  assign modifierField   = modifier_reg;
  assign secondWord      = second_reg;

endmodule // fetch_bus_ctl

// *** hw/fetch_ctl_pkg.sv ***
// shared constants for the instruction fetch and bus control block
package fetch_ctl_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int NIB_W      = 4;
  localparam int ADDR_W     = 12;
  localparam int IDX_DEPTH  = 16;
  localparam int IDX_AW     = 4;
  localparam int STACK_LVLS = 3;
  localparam int BANK_W     = 3;
  localparam int BANK_LINES = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int CYCLE_CLOCKS      = 8;
  localparam int RESET_MIN_CYCLES  = 8;
  localparam int RESET_MIN_CLOCKS  = RESET_MIN_CYCLES * CYCLE_CLOCKS;
  localparam int RET_ADVANCE       = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PC_RESET   = 12'h000;
  localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;
  localparam logic [NIB_W-1:0]  NIB_ZERO   = 4'h0;

  // ---------------------------------------------------------------
  // operation code field values
  // ---------------------------------------------------------------
  localparam logic [NIB_W-1:0] OP_COND_JUMP  = 4'h1;
  localparam logic [NIB_W-1:0] OP_PAIR_GROUP = 4'h2;
  localparam logic [NIB_W-1:0] OP_JUMP       = 4'h4;
  localparam logic [NIB_W-1:0] OP_CALL       = 4'h5;
  localparam logic [NIB_W-1:0] OP_SKIP_ZERO  = 4'h7;
  localparam logic [NIB_W-1:0] OP_RETURN     = 4'hC;
  localparam logic [NIB_W-1:0] OP_IO_GROUP   = 4'hE;
  localparam logic [NIB_W-1:0] OP_ACC_GROUP  = 4'hF;

  // modifier values
  localparam logic [NIB_W-1:0] MOD_BANK_DESIGNATE = 4'hD;
  localparam int DIR_BIT  = 3;
  localparam int PAIR_BIT = 0;

  // ---------------------------------------------------------------
  // subcycles of one instruction cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SUB_A1, SUB_A2, SUB_A3, SUB_M1, SUB_M2, SUB_X1, SUB_X2, SUB_X3
  } subcycle_t;

endpackage

// *** hw/index_reg_file.sv ***
// sixteen-nibble index store with reset sweep
`timescale 1ns/1ps
module index_reg_file
(
  input  wire logic                                 ref_clk,
  input  wire logic                                 sweepClear,
  input  wire logic                                 writeEn,
  input  wire logic [fetch_ctl_pkg::IDX_AW-1:0]     writeAddr,
  input  wire logic [fetch_ctl_pkg::NIB_W-1:0]      writeData,
  input  wire logic [fetch_ctl_pkg::IDX_AW-1:0]     readAddr,
  output logic      [fetch_ctl_pkg::NIB_W-1:0]      readData
);
  import fetch_ctl_pkg::*;

  logic [NIB_W-1:0]  cells [IDX_DEPTH];
  logic [IDX_AW-1:0] sweepPtr_reg;
  logic [IDX_AW-1:0] sweepPtr_next;

  // ---------------------------------------------------------------
  // refresh pointer
  // ---------------------------------------------------------------
  // no reset: any start point sweeps all cells in sixteen clocks
  always_comb
  begin
    sweepPtr_next = sweepPtr_reg + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    sweepPtr_reg <= sweepPtr_next;
    if (sweepClear)
      cells[sweepPtr_reg] <= NIB_ZERO;
    else if (writeEn)
      cells[writeAddr] <= writeData;
  end

  assign readData = cells[readAddr];

endmodule // index_reg_file

// *** hw/pin_sync3.sv ***
// three-stage synchroniser for a pin level
`timescale 1ns/1ps
module pin_sync3
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      pinLevel
);

  logic stage1Reg;
  logic stage2Reg;
  logic stage3Reg;
  logic levelReg;
  logic levelNext;

  // ---------------------------------------------------------------
  // change taken once second and third stages agree
  // ---------------------------------------------------------------
  always_comb
  begin
    levelNext = levelReg;
    if (stage2Reg == stage3Reg)
      levelNext = stage3Reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
      levelReg  <= 1'b0;
    end
    else
    begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      levelReg  <= levelNext;
    end
  end

  assign pinLevel = levelReg;

endmodule // pin_sync3

// *** testbench/fetch_bus_ctl_monitor.sv ***
// port checker for the fetch and bus control block
`timescale 1ns/1ps
module fetch_bus_ctl_monitor
(
  input wire logic                            ref_clk,
  input wire logic                            reset_n,
  input wire logic [fetch_ctl_pkg::NIB_W-1:0] dataBusOut,
  input wire logic [fetch_ctl_pkg::NIB_W-1:0] dataBusOe_n,
  input wire logic                            cycleStart,
  input wire logic [fetch_ctl_pkg::BANK_LINES-1:0] ramBankCmd,
  input wire logic                            progMemCmd,
  input wire logic                            portAddrLoad,
  input wire logic                            inputEnable,
  input wire logic                            outputEnable,
  input wire logic                            inputLatchClear,
  input wire logic [fetch_ctl_pkg::NIB_W-1:0] opcodeField,
  input wire logic                            secondWord
);
  import fetch_ctl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // edges since reset release, saturating
  // ---------------------------------------------------------------
  logic [1:0] edgeCnt_reg;
  logic [1:0] edgeCnt_next;
  always_comb
    edgeCnt_next = (edgeCnt_reg == 2'h3) ? edgeCnt_reg : edgeCnt_reg + 2'h1;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      edgeCnt_reg <= 2'h0;
    else
      edgeCnt_reg <= edgeCnt_next;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  first_fetch_a: assert property (
    edgeCnt_reg == 2'h1 |-> cycleStart && dataBusOut == 4'h0 &&
    dataBusOe_n == 4'h0 && ramBankCmd == 4'h0)
    else $error("first cycle not at address zero");
  cycle_period_a: assert property (
    cycleStart |=> !cycleStart [*7] ##1 cycleStart)
    else $error("cycle marker spacing wrong");
  addr_slices_a: assert property (
    cycleStart |-> dataBusOe_n == 4'h0 ##1 dataBusOe_n == 4'h0
    ##1 (dataBusOe_n == 4'h0 && progMemCmd))
    else $error("address slices not driven");
  bus_release_a: assert property (
    cycleStart |-> ##3 (dataBusOe_n == 4'hF) [*3])
    else $error("bus not released during fetch");
  strobe_slot_a: assert property (
    inputEnable || outputEnable || portAddrLoad |-> $past(cycleStart, 6))
    else $error("strobe outside X2");
  latch_clear_a: assert property (
    inputEnable |=> inputLatchClear && !inputEnable)
    else $error("no input latch clear after read");
  bank_line_a: assert property (
    ramBankCmd != 4'h0 |-> $onehot(ramBankCmd) &&
    ($past(cycleStart, 4) || $past(cycleStart, 6)))
    else $error("bank line outside M2 or X2");
  select_pair_a: assert property (
    portAddrLoad |-> progMemCmd && ramBankCmd != 4'h0 &&
    dataBusOe_n == 4'h0 ##1 dataBusOe_n == 4'h0)
    else $error("select target pair not sent");
  two_cycle_a: assert property (
    $rose(secondWord) |-> cycleStart ##8 (cycleStart && !secondWord))
    else $error("second word cycle misaligned");
  opcode_load_a: assert property (
    $changed(opcodeField) |-> $past(cycleStart, 4))
    else $error("operation code loaded outside M1");
endmodule // fetch_bus_ctl_monitor

bind fetch_bus_ctl fetch_bus_ctl_monitor MON
(
  .ref_clk(ref_clk), .reset_n(reset_n), .dataBusOut(dataBusOut),
  .dataBusOe_n(dataBusOe_n), .cycleStart(cycleStart),
  .ramBankCmd(ramBankCmd), .progMemCmd(progMemCmd),
  .portAddrLoad(portAddrLoad), .inputEnable(inputEnable),
  .outputEnable(outputEnable), .inputLatchClear(inputLatchClear),
  .opcodeField(opcodeField), .secondWord(secondWord)
);

// *** testbench/fetch_bus_ctl_tb.sv ***
// self-checking bench for the fetch and bus control block
`timescale 1ns/1ps
module fetch_bus_ctl_tb;
  import fetch_ctl_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  logic [3:0]  busLevel;
  logic [3:0]  dataBusOut;
  logic [3:0]  dataBusOe_n;
  logic [3:0]  accIn;
  logic        condTrue;
  logic        cycleStart;
  logic [3:0]  ramBankCmd;
  logic        progMemCmd;
  logic        portAddrLoad;
  logic        inputEnable;
  logic        outputEnable;
  logic        inputLatchClear;
  logic        secondWord;
  logic [3:0]  opcodeField;
  logic [3:0]  modifierField;
  logic [11:0] busS [8];
  logic [11:0] flS [8];
  logic [11:0] addr;
  int          n_fail;
  int          checked;

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  fetch_bus_ctl DUT
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .dataBusIn(busLevel),
    .dataBusOut(dataBusOut), .dataBusOe_n(dataBusOe_n), .accIn(accIn),
    .condTrue(condTrue), .cycleStart(cycleStart), .ramBankCmd(ramBankCmd),
    .progMemCmd(progMemCmd), .portAddrLoad(portAddrLoad),
    .inputEnable(inputEnable), .outputEnable(outputEnable),
    .inputLatchClear(inputLatchClear), .opcodeField(opcodeField),
    .modifierField(modifierField), .secondWord(secondWord)
  );

  nibble_bus_partner PM
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .cycleStart(cycleStart),
    .inputEnable(inputEnable), .portAddrLoad(portAddrLoad),
    .outputEnable(outputEnable), .dataBusOut(dataBusOut),
    .dataBusOe_n(dataBusOe_n), .busLevel(busLevel)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the index sweep needs only sixteen clocks, but every reset holds the full minimum
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (RESET_MIN_CLOCKS + 3) @(negedge ref_clk);
    chk({4'h0, dataBusOe_n, dataBusOut}, 12'h000);
    chk({ramBankCmd, 1'b0, cycleStart, progMemCmd, portAddrLoad,
         inputEnable, outputEnable, inputLatchClear, 1'b0}, 12'h000);
    reset_n = 1'b1;
  endtask

  // records one whole instruction cycle, subcycle by subcycle
  task automatic step;
    int w;
    w = 0;
    while (cycleStart !== 1'b1 && w < 16)
    begin
      @(negedge ref_clk);
      w++;
    end
    for (int s = 0; s < 8; s++)
    begin
      busS[s] = {4'h0, dataBusOe_n, dataBusOut};
      flS[s] = {ramBankCmd, 1'b0, cycleStart, progMemCmd, portAddrLoad,
                inputEnable, outputEnable, inputLatchClear, secondWord};
      @(negedge ref_clk);
    end
    addr = {busS[2][3:0], busS[1][3:0], busS[0][3:0]};
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_io_write;
    PM.mem[0] = 8'hE0;
    accIn = 4'h6;
    do_reset();
    step();
    chk(addr, 12'h000);
    chk({4'h0, opcodeField, modifierField}, 12'h0E0);
    chk(flS[4], 12'h100);
    chk(flS[6], 12'h004);
    chk(busS[6], 12'h006);
    step();
    chk(addr, 12'h001);
  endtask

  task automatic t_io_read;
    PM.mem[0] = 8'hE8;
    do_reset();
    step();
    chk(flS[4], 12'h100);
    chk(flS[6], 12'h008);
    chk(busS[6] & 12'h0F0, 12'h0F0);
    chk(flS[7], 12'h002);
  endtask

  task automatic t_bank;
    PM.mem[0] = 8'hFD;
    PM.mem[1] = 8'hE0;
    PM.mem[2] = 8'h40;
    PM.mem[3] = 8'h00;
    do_reset();
    for (int b = 0; b < 4; b++)
    begin
      accIn = 4'(b);
      step();
      chk(flS[4], 12'h000);
      step();
      chk(flS[4], {4'(1 << b), 8'h00});
      step();
      step();
    end
  endtask

  task automatic t_pair;
    PM.mem[0] = 8'h20;
    PM.mem[1] = 8'hAB;
    PM.mem[2] = 8'h21;
    PM.mem[3] = 8'hE0;
    accIn = 4'h5;
    do_reset();
    step();
    chk(flS[0], 12'h040);
    step();
    chk(flS[0], 12'h041);
    chk(addr, 12'h001);
    step();
    chk(addr, 12'h002);
    chk(flS[6], 12'h130);
    chk(busS[6], 12'h00A);
    chk(busS[7], 12'h00B);
    step();
    chk({4'h0, PM.sel_reg}, 12'h0AB);
    chk({8'h00, PM.port_reg}, 12'h005);
    chk({8'h00, PM.ram[2][11]}, 12'h005);
  endtask

  task automatic t_cond;
    for (int k = 0; k < 4; k++)
    begin
      PM.mem[0] = k[1] ? 8'h71 : 8'h11;
      PM.mem[1] = 8'h40;
      condTrue = k[0];
      do_reset();
      step();
      step();
      step();
      chk(addr, k[0] ? 12'h040 : 12'h002);
    end
  endtask

  task automatic t_calls;
    logic [11:0] exp [8];
    exp = '{12'h000, 12'h020, 12'h030, 12'h040,
            12'h050, 12'h042, 12'h032, 12'h022};
    for (int i = 0; i < 4; i++)
    begin
      PM.mem[exp[i]] = 8'h50;
      PM.mem[exp[i] + 12'h001] = {exp[i + 1][7:4], 4'h0};
      PM.mem[exp[i + 4]] = 8'hC0;
    end
    do_reset();
    for (int i = 0; i < 8; i++)
    begin
      step();
      chk(addr, exp[i]);
      if (i < 4)
        step();
    end
    step();
    chk({11'h000, addr == 12'h002}, 12'h000);
  endtask

  initial
  begin
    reset_n = 1'b0;
    accIn = 4'h0;
    condTrue = 1'b0;
    n_fail = 0;
    checked = 0;
    repeat (3) @(negedge ref_clk);
    t_io_write();
    t_io_read();
    t_bank();
    t_pair();
    t_cond();
    t_calls();
    wrap_up();
  end

  // roughly eight times the expected run length
  initial
  begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule // fetch_bus_ctl_tb

// *** testbench/nibble_bus_partner.sv ***
// program memory and port card model on the shared nibble bus
`timescale 1ns/1ps
module nibble_bus_partner
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       cycleStart,
  input wire logic       inputEnable,
  input wire logic       portAddrLoad,
  input wire logic       outputEnable,
  input wire logic [3:0] dataBusOut,
  input wire logic [3:0] dataBusOe_n,
  output logic     [3:0] busLevel
);
  logic [7:0]  mem [4096];
  logic [2:0]  sub_reg;
  logic [11:0] addr_reg;
  logic [3:0]  last_reg;
  logic        drive;
  logic [3:0]  pData;
  logic [7:0]  sel_reg;
  logic        selLow_reg;
  logic [3:0]  port_reg;
  logic [3:0]  ram [4][16];
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // ---------------------------------------------------------------
  // wire level: an undriven line shows the inverse of its last level
  // so a stale value never passes for a good one
  // ---------------------------------------------------------------
  always_comb
  begin
    drive = (sub_reg == 3'h3) || (sub_reg == 3'h4) || inputEnable;
    pData = inputEnable ? 4'h9 :
            (sub_reg == 3'h3) ? mem[addr_reg][7:4] : mem[addr_reg][3:0];
    for (int i = 0; i < 4; i++)
      busLevel[i] = !dataBusOe_n[i] ? dataBusOut[i] :
                    drive ? pData[i] : !last_reg[i];
  end
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sub_reg  <= 3'h7;
      addr_reg <= 12'h000;
      last_reg <= 4'h0;
      sel_reg <= 8'h00;
      selLow_reg <= 1'b0;
      port_reg <= 4'h0;
    end
    else
    begin
      last_reg <= busLevel;
      selLow_reg <= portAddrLoad;
      if (portAddrLoad)
        sel_reg[7:4] <= busLevel;
      if (selLow_reg)
        sel_reg[3:0] <= busLevel;
      // one chip only: register and main character from the select
      if (outputEnable)
      begin
        port_reg <= busLevel;
        ram[sel_reg[5:4]][sel_reg[3:0]] <= busLevel;
      end
      sub_reg  <= cycleStart ? 3'h1 : sub_reg + 3'h1;
      case (sub_reg)
        3'h0: addr_reg[3:0] <= busLevel;
        3'h1: addr_reg[7:4] <= busLevel;
        3'h2: addr_reg[11:8] <= busLevel;
        default: ;
      endcase
    end
endmodule // nibble_bus_partner
